// ### core/agsu_pkg.sv
// Purpose: shared constants for the address-line gate and cpu reset speed-up logic
// Assumes: 200 MHz core clock, byte-wide host and configuration accesses
// Notes:   pulse timing counts are derived from the printed times
`default_nettype none

package agsu_pkg;

  // configuration byte and host port decode
  localparam logic [7:0] CFG_INDEX       = 8'hf0;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam int         CFG_P92_BIT     = 2;
  localparam int         CFG_GATE_BIT    = 1;
  localparam int         CFG_RST_BIT     = 0;

  // fast system control port
  localparam logic [7:0] P92_ADDR        = 8'h92;
  localparam logic [7:0] P92_RESET       = 8'h24;
  localparam logic [7:0] P92_FIXED       = 8'h24;
  localparam int         P92_A20_BIT     = 1;
  localparam int         P92_RST_BIT     = 0;

  // commands and data fields
  localparam logic [7:0] CMD_GATE        = 8'hd1;
  localparam logic [7:0] CMD_NOP         = 8'hff;
  localparam logic [7:0] CMD_PULSE       = 8'hfe;
  localparam int         DATA_GATE_BIT   = 1;
  localparam int         DATA_RST_BIT    = 0;

  // reset pulse timing
  localparam int         CLK_PERIOD_PS   = 5000;
  localparam int         DELAY_NS        = 14000;
  localparam int         WIDTH_NS        = 6000;
  localparam int         DELAY_CYC       = (DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         WIDTH_CYC       = (WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         TMR_W           = 13;

  typedef enum logic {
    AGSU_IDLE,
    AGSU_GOT_CMD
  } agsu_state_e;

endpackage : agsu_pkg

`default_nettype wire

// ### core/agsu_top.sv
// Purpose: hardware speed-up of the address-line gate and cpu reset for the keyboard host port
// Assumes: all inputs synchronous to core_clk_in; one host access per strobe cycle
// Notes:   pins float after reset until the configuration byte is first written
`default_nettype none

module agsu_top (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       host_wr_in,
  input  wire logic       host_rd_in,
  input  wire logic       kbd_cs_in,
  input  wire logic       p92_cs_in,
  input  wire logic       port_select_addr_bit_in,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_rdata_out,
  input  wire logic       cfg_wr_in,
  input  wire logic [7:0] cfg_index_in,
  input  wire logic [7:0] cfg_data_in,
  output logic      [7:0] cfg_rdata_out,
  input  wire logic       fw_gate_in,
  input  wire logic       fw_reset_n_in,
  input  wire logic       fw_obf_in,
  input  wire logic       fw_ibf_clr_in,
  input  wire logic       gpio_polarity_in,
  output logic            fw_wr_out,
  output logic            fw_is_cmd_out,
  output logic      [7:0] fw_data_out,
  output logic            input_buffer_full_flag_out,
  output logic            output_full_pin_out,
  output logic            addr_line_mask_gate_out,
  output logic            addr_line_mask_gate_oe_n_out,
  output logic            cpu_reset_out,
  output logic            cpu_reset_oe_n_out
);

  typedef struct packed {
    agsu_pkg::agsu_state_e           st;
    logic [7:0]                      cfg;
    logic                            p92_a20;
    logic                            p92_rst;
    logic                            gate_latch;
    logic                            rst_latch;
    logic [agsu_pkg::TMR_W-1:0]      kbd_cnt;
    logic [agsu_pkg::TMR_W-1:0]      p92_cnt;
    logic                            input_buffer_full_flag;
    logic                            drive_en;
    logic                            fwd_wr;
    logic                            fwd_cmd;
    logic [7:0]                      fwd_data;
    logic [7:0]                      host_rdata;
    logic [7:0]                      cfg_rdata;
    logic                            gate;
    logic                            rst;
    logic                            obf;
  } agsu_state_s;

  localparam logic [agsu_pkg::TMR_W-1:0] DLY = agsu_pkg::TMR_W'(agsu_pkg::DELAY_CYC);
  localparam logic [agsu_pkg::TMR_W-1:0] END = agsu_pkg::TMR_W'(agsu_pkg::DELAY_CYC + agsu_pkg::WIDTH_CYC);
  localparam logic [agsu_pkg::TMR_W-1:0] ONE = agsu_pkg::TMR_W'(1);

  function automatic logic [agsu_pkg::TMR_W-1:0] agsu_tick(input logic [agsu_pkg::TMR_W-1:0] cnt);
    if (cnt == '0 || cnt == END) begin
      agsu_tick = '0;
    end else begin
      agsu_tick = cnt + ONE;
    end
  endfunction : agsu_tick

  // low only inside the pulse window, after the full delay
  function automatic logic agsu_pulse_n(input logic [agsu_pkg::TMR_W-1:0] cnt);
    agsu_pulse_n = !(cnt > DLY);
  endfunction : agsu_pulse_n

  agsu_state_s cur;
  agsu_state_s next_cur;

  logic kbd_wr;
  logic is_cmd;
  logic p92_en;
  logic hw_rst_n;
  logic sel_rst_n;
  logic sel_gate;
  logic ibf_set;

  always_comb begin
    next_cur        = cur;
    next_cur.fwd_wr = 1'b0;
    ibf_set         = 1'b0;
    kbd_wr          = host_wr_in && kbd_cs_in;
    // address bit splits command from data
    is_cmd          = port_select_addr_bit_in;
    p92_en          = cur.cfg[agsu_pkg::CFG_P92_BIT];

    if (cfg_wr_in && cfg_index_in == agsu_pkg::CFG_INDEX) begin
      next_cur.cfg      = cfg_data_in;
      next_cur.drive_en = 1'b1;
    end
    if (cfg_index_in == agsu_pkg::CFG_INDEX) begin
      next_cur.cfg_rdata = cur.cfg;
    end else begin
      next_cur.cfg_rdata = 8'h00;
    end

    if (kbd_wr && is_cmd) begin
      if (host_data_in == agsu_pkg::CMD_NOP) begin
        next_cur.st = cur.st;
      end else if (host_data_in == agsu_pkg::CMD_GATE && cur.cfg[agsu_pkg::CFG_GATE_BIT]) begin
        next_cur.st = agsu_pkg::AGSU_GOT_CMD;
      end else if (cur.st == agsu_pkg::AGSU_GOT_CMD) begin
        ibf_set     = 1'b1;
        next_cur.st = agsu_pkg::AGSU_IDLE;
      end else if (host_data_in == agsu_pkg::CMD_PULSE && cur.cfg[agsu_pkg::CFG_RST_BIT]) begin
        if (cur.kbd_cnt == '0) begin
          next_cur.kbd_cnt = ONE;
        end
      end else begin
        ibf_set           = 1'b1;
        next_cur.fwd_wr   = 1'b1;
        next_cur.fwd_cmd  = 1'b1;
        next_cur.fwd_data = host_data_in;
      end
    end else if (kbd_wr) begin
      if (cur.st == agsu_pkg::AGSU_GOT_CMD) begin
        // gate latch from data bit 1
        next_cur.gate_latch = host_data_in[agsu_pkg::DATA_GATE_BIT];
        // reset latch from data bit 0
        next_cur.rst_latch  = host_data_in[agsu_pkg::DATA_RST_BIT];
        next_cur.st         = agsu_pkg::AGSU_IDLE;
      end else begin
        // extra data reaches firmware and sets flag
        ibf_set           = 1'b1;
        next_cur.fwd_wr   = 1'b1;
        next_cur.fwd_cmd  = 1'b0;
        next_cur.fwd_data = host_data_in;
      end
    end

    // set wins over a firmware clear in the same cycle
    if (ibf_set) begin
      next_cur.input_buffer_full_flag = 1'b1;
    end else if (fw_ibf_clr_in) begin
      next_cur.input_buffer_full_flag = 1'b0;
    end

    next_cur.host_rdata = 8'h00;
    if (p92_cs_in && p92_en) begin
      if (host_wr_in) begin
        next_cur.p92_a20 = host_data_in[agsu_pkg::P92_A20_BIT];
        next_cur.p92_rst = host_data_in[agsu_pkg::P92_RST_BIT];
        // rising bit 0 starts the fast pulse
        if (host_data_in[agsu_pkg::P92_RST_BIT] && !cur.p92_rst && cur.p92_cnt == '0) begin
          next_cur.p92_cnt = ONE;
        end
      end
      if (host_rd_in) begin
        next_cur.host_rdata = agsu_pkg::P92_FIXED | {6'h00, cur.p92_a20, cur.p92_rst};
      end
    end

    // timers advance unless just started above
    if (cur.kbd_cnt != '0) begin
      next_cur.kbd_cnt = agsu_tick(cur.kbd_cnt);
    end
    if (cur.p92_cnt != '0) begin
      next_cur.p92_cnt = agsu_tick(cur.p92_cnt);
    end

    // data bit 0 also gates the speed-up reset level
    hw_rst_n = agsu_pulse_n(cur.kbd_cnt) && cur.rst_latch;
    sel_rst_n = cur.cfg[agsu_pkg::CFG_RST_BIT] ? hw_rst_n : fw_reset_n_in;
    sel_gate = cur.cfg[agsu_pkg::CFG_GATE_BIT] ? cur.gate_latch : fw_gate_in;
    // merge with fast port when enabled
    if (p92_en) begin
      sel_rst_n = sel_rst_n && agsu_pulse_n(cur.p92_cnt);
      sel_gate  = sel_gate || cur.p92_a20;
    end
    next_cur.gate = sel_gate ^ gpio_polarity_in;
    next_cur.rst  = sel_rst_n ^ gpio_polarity_in;
    // output-full pin masked during a handled pair
    next_cur.obf  = fw_obf_in && (cur.st == agsu_pkg::AGSU_IDLE);
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cur            <= '0;
      cur.st         <= agsu_pkg::AGSU_IDLE;
      cur.cfg        <= agsu_pkg::CFG_RESET;
      cur.p92_a20    <= agsu_pkg::P92_RESET[agsu_pkg::P92_A20_BIT];
      cur.p92_rst    <= agsu_pkg::P92_RESET[agsu_pkg::P92_RST_BIT];
      cur.rst_latch  <= 1'b1;
      cur.rst        <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign host_rdata_out               = cur.host_rdata;
  assign cfg_rdata_out                = cur.cfg_rdata;
  assign fw_wr_out                    = cur.fwd_wr;
  assign fw_is_cmd_out                = cur.fwd_cmd;
  assign fw_data_out                  = cur.fwd_data;
  assign input_buffer_full_flag_out   = cur.input_buffer_full_flag;
  assign output_full_pin_out          = cur.obf;
  assign addr_line_mask_gate_out      = cur.gate;
  assign cpu_reset_out                = cur.rst;
  assign addr_line_mask_gate_oe_n_out = !cur.drive_en;
  assign cpu_reset_oe_n_out           = !cur.drive_en;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_gate_cmd;
    kbd_wr && is_cmd && host_data_in == agsu_pkg::CMD_GATE && cur.cfg[agsu_pkg::CFG_GATE_BIT];
  endsequence

  sequence s_data_wr;
    kbd_wr && !is_cmd;
  endsequence

  chk_cfg_write: assert property (
    cfg_wr_in && cfg_index_in == agsu_pkg::CFG_INDEX |=> cur.cfg == $past(cfg_data_in) && cur.drive_en)
    else $error("config byte not stored");

  chk_gate_pair: assert property (
    s_gate_cmd ##1 (s_data_wr and !cfg_wr_in) |=>
      cur.gate_latch == $past(host_data_in[agsu_pkg::DATA_GATE_BIT]) &&
      cur.rst_latch == $past(host_data_in[agsu_pkg::DATA_RST_BIT]))
    else $error("gate pair did not load latches");

  chk_pair_no_flag: assert property (
    ((cur.st == agsu_pkg::AGSU_GOT_CMD && !fw_ibf_clr_in) and s_data_wr) |=>
      cur.input_buffer_full_flag == $past(cur.input_buffer_full_flag) && !cur.fwd_wr)
    else $error("handled pair touched flag");

  chk_pins_float: assert property (
    !cur.drive_en && !(cfg_wr_in && cfg_index_in == agsu_pkg::CFG_INDEX) |=>
      addr_line_mask_gate_oe_n_out && cpu_reset_oe_n_out)
    else $error("pin driven before configuration");

  chk_nop_holds: assert property (
    kbd_wr && is_cmd && host_data_in == agsu_pkg::CMD_NOP && !fw_ibf_clr_in |=>
      $stable(cur.gate_latch) && $stable(cur.input_buffer_full_flag))
    else $error("no-op command changed state");

  chk_bad_cmd: assert property (
    cur.st == agsu_pkg::AGSU_GOT_CMD && kbd_wr && is_cmd && host_data_in != agsu_pkg::CMD_GATE &&
      host_data_in != agsu_pkg::CMD_NOP |=> cur.input_buffer_full_flag && $stable(cur.gate_latch) && cur.st == agsu_pkg::AGSU_IDLE)
    else $error("broken sequence not flagged");

  // delay phase keeps the pin at its idle level
  chk_pulse_delay: assert property (
    cur.kbd_cnt != '0 && cur.kbd_cnt <= DLY && cur.rst_latch && cur.cfg[agsu_pkg::CFG_RST_BIT] && !p92_en |=>
      cur.rst == !$past(gpio_polarity_in))
    else $error("reset pulse began too early");

  // whole width window shows the active level
  chk_pulse_window: assert property (
    cur.kbd_cnt > DLY && cur.cfg[agsu_pkg::CFG_RST_BIT] |=> cur.rst == $past(gpio_polarity_in))
    else $error("reset pulse missing after delay");

  chk_p92_gated: assert property (
    p92_cs_in && host_wr_in && !p92_en |=> $stable(cur.p92_a20) && $stable(cur.p92_rst))
    else $error("fast port written while disabled");

  chk_fast_a20: assert property (
    p92_en && cur.p92_a20 |=> cur.gate == !$past(gpio_polarity_in))
    else $error("fast mask drive did not force gate");

endmodule : agsu_top

`default_nettype wire

// ### verif/agsu_host_model.sv
// Purpose: host processor model for the keyboard and fast control ports
// Assumes: one strobe cycle per access, no wait states
// Notes:   released data bus shows the inverse of the last byte
`default_nettype none
module agsu_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output var  logic       wr_out,
  output var  logic       rd_out,
  output var  logic       kbd_cs_out,
  output var  logic       p92_cs_out,
  output var  logic       a2_out,
  output var  logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_out, rd_out, kbd_cs_out, p92_cs_out, a2_out} = 5'h00;
    data_out = 8'h5a;
  end
  // kind 0 data, 1 command, 2 fast port write, 3 fast port read
  task automatic access(input logic [1:0] kind, input logic [7:0] d, output logic [7:0] rd);
    @(posedge clk_in);
    a2_out     <= (kind == 2'h1);
    kbd_cs_out <= !kind[1];
    p92_cs_out <= kind[1];
    wr_out     <= (kind != 2'h3);
    rd_out     <= (kind == 2'h3);
    data_out   <= d;
    @(posedge clk_in);
    {wr_out, rd_out, kbd_cs_out, p92_cs_out} <= 4'h0;
    data_out <= ~d;
    #1;
    rd = rdata_in;
  endtask : access
endmodule : agsu_host_model
`default_nettype wire

// ### verif/agsu_top_tb_top.sv
// Purpose: self-checking bench for the gate and reset speed-up block
// Assumes: 200 MHz clock, host model strobes one cycle per access
// Notes:   pulse timing uses the full delay and width counts
`default_nettype none
module agsu_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk       = 1'b0;
  logic       rst_n     = 1'b0;
  logic       cfg_wr    = 1'b0;
  logic [7:0] cfg_index = 8'hf0;
  logic [7:0] cfg_data  = 8'h00;
  logic       fw_gate   = 1'b0;
  logic       fw_rst_n  = 1'b1;
  logic       fw_obf    = 1'b0;
  logic       fw_clr    = 1'b0;
  logic       pol       = 1'b0;
  logic       wr, rd, kcs, pcs, a2, flag, obf_pin, gate, gate_oe_n, cpu_rst, rst_oe_n, fw_wr, fw_cmd;
  logic [7:0] hdata, rdata, cfg_rdata, rd_val, fw_data;
  int         fails, samples_checked;

  agsu_host_model i_agsu_host_model (.clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
    .kbd_cs_out(kcs), .p92_cs_out(pcs), .a2_out(a2), .data_out(hdata));

  agsu_top i_agsu_top (.core_clk_in(clk), .rst_n_in(rst_n), .host_wr_in(wr), .host_rd_in(rd),
    .kbd_cs_in(kcs), .p92_cs_in(pcs), .port_select_addr_bit_in(a2), .host_data_in(hdata),
    .host_rdata_out(rdata), .cfg_wr_in(cfg_wr), .cfg_index_in(cfg_index), .cfg_data_in(cfg_data),
    .cfg_rdata_out(cfg_rdata), .fw_gate_in(fw_gate), .fw_reset_n_in(fw_rst_n), .fw_obf_in(fw_obf),
    .fw_ibf_clr_in(fw_clr), .gpio_polarity_in(pol),
    .fw_wr_out(fw_wr), .fw_is_cmd_out(fw_cmd), .fw_data_out(fw_data),
    .input_buffer_full_flag_out(flag), .output_full_pin_out(obf_pin), .addr_line_mask_gate_out(gate),
    .addr_line_mask_gate_oe_n_out(gate_oe_n), .cpu_reset_out(cpu_rst), .cpu_reset_oe_n_out(rst_oe_n));

  initial forever #2.5 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic h(input logic [1:0] kind, input logic [7:0] d);
    i_agsu_host_model.access(kind, d, rd_val);
  endtask : h

  task automatic cfg(input logic [7:0] v);
    @(posedge clk);
    cfg_wr   <= 1'b1;
    cfg_data <= v;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cyc(3);
  endtask : cfg

  task automatic t_soft;
    check(8'(gate_oe_n), 8'h01);
    check(8'(rst_oe_n), 8'h01);
    @(posedge clk);
    fw_gate  <= 1'b1;
    fw_rst_n <= 1'b0;
    cfg(8'h00);
    check(8'(gate_oe_n), 8'h00);
    check(8'(gate), 8'h01);
    check(8'(cpu_rst), 8'h00);
    // firmware levels held: the speed-up sources must win now
    cfg(8'h03);
    check(8'(gate), 8'h00);
    check(8'(cpu_rst), 8'h01);
    check(cfg_rdata, 8'h03);
    @(posedge clk);
    fw_gate   <= 1'b0;
    fw_rst_n  <= 1'b1;
    cfg_index <= 8'h10;
    cyc(2);
    check(cfg_rdata, 8'h00);
    @(posedge clk);
    cfg_index <= agsu_pkg::CFG_INDEX;
  endtask : t_soft

  task automatic t_gate;
    @(posedge clk);
    fw_obf <= 1'b1;
    h(2'h1, agsu_pkg::CMD_GATE);
    cyc(2);
    check(8'(obf_pin), 8'h00);
    h(2'h0, 8'h03);
    check(8'(fw_wr), 8'h00);
    cyc(3);
    check(8'(gate), 8'h01);
    check(8'(obf_pin), 8'h01);
    check(8'(flag), 8'h00);
    h(2'h1, agsu_pkg::CMD_GATE);
    h(2'h1, agsu_pkg::CMD_GATE);
    h(2'h0, 8'hfd);
    h(2'h1, agsu_pkg::CMD_NOP);
    cyc(3);
    check(8'(gate), 8'h00);
    check(8'(flag), 8'h00);
    h(2'h1, agsu_pkg::CMD_GATE);
    h(2'h0, 8'h02);
    cyc(3);
    check(8'(cpu_rst), 8'h00);
    h(2'h1, agsu_pkg::CMD_GATE);
    h(2'h0, 8'h01);
    cyc(3);
    check(8'(cpu_rst), 8'h01);
  endtask : t_gate

  task automatic clear_flag;
    @(posedge clk);
    fw_clr <= 1'b1;
    @(posedge clk);
    fw_clr <= 1'b0;
    cyc(2);
    check(8'(flag), 8'h00);
  endtask : clear_flag

  task automatic t_bad;
    h(2'h1, agsu_pkg::CMD_GATE);
    h(2'h1, 8'haa);
    check(8'(fw_wr), 8'h00);
    h(2'h1, agsu_pkg::CMD_NOP);
    cyc(3);
    check(8'(flag), 8'h01);
    check(8'(gate), 8'h00);
    clear_flag();
    h(2'h1, agsu_pkg::CMD_GATE);
    h(2'h0, 8'h03);
    h(2'h0, 8'h03);
    check(8'(fw_wr), 8'h01);
    check(8'(fw_cmd), 8'h00);
    check(fw_data, 8'h03);
    cyc(3);
    check(8'(flag), 8'h01);
    h(2'h1, 8'h20);
    check(8'(fw_wr), 8'h01);
    check(8'(fw_cmd), 8'h01);
    check(fw_data, 8'h20);
    clear_flag();
  endtask : t_bad

  // taken at the edge after the strobe: high through 2800 cycles, low across 1200
  task automatic t_pulse(input logic [1:0] kind, input logic [7:0] d);
    h(kind, d);
    cyc(2799);
    check(8'(cpu_rst), 8'h01);
    cyc(2);
    check(8'(cpu_rst), 8'h00);
    cyc(1199);
    check(8'(cpu_rst), 8'h00);
    cyc(25);
    check(8'(cpu_rst), 8'h01);
    check(8'(flag), 8'h00);
  endtask : t_pulse

  task automatic t_p92;
    h(2'h1, agsu_pkg::CMD_GATE);
    h(2'h0, 8'h01);
    cfg(8'h07);
    h(2'h2, 8'h02);
    cyc(3);
    check(8'(gate), 8'h01);
    h(2'h3, 8'h00);
    check(rd_val, 8'h26);
    t_pulse(2'h2, 8'h03);
    h(2'h2, 8'h02);
    cfg(8'h03);
    check(8'(gate), 8'h00);
    // a write while disabled must not reach the port bits
    h(2'h2, 8'h00);
    h(2'h3, 8'h00);
    check(rd_val, 8'h00);
    cfg(8'h07);
    h(2'h3, 8'h00);
    check(rd_val, 8'h26);
    check(8'(gate), 8'h01);
    h(2'h2, 8'h00);
    cfg(8'h03);
  endtask : t_p92

  task automatic t_pol;
    @(posedge clk);
    pol <= 1'b1;
    cyc(3);
    check(8'(gate), 8'h01);
    check(8'(cpu_rst), 8'h00);
    @(posedge clk);
    pol <= 1'b0;
    cyc(3);
  endtask : t_pol

  // mid-run reset returns pins to float and the byte to its reset value
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    check(8'(gate_oe_n), 8'h01);
    check(8'(rst_oe_n), 8'h01);
    check(cfg_rdata, 8'h00);
  endtask : t_reset

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    t_soft();
    t_gate();
    t_bad();
    t_pulse(2'h1, agsu_pkg::CMD_PULSE);
    t_p92();
    t_pol();
    t_reset();
    final_report();
  end

  // two pulses dominate the run; this leaves ample margin
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule : agsu_top_tb_top
`default_nettype wire
